// *** stop_cfg_pkg.sv ***
// Purpose: Shared constants and types for the protection and stop block
// Assumes: 20 MHz clock, parameter port addressed by object index
// Notes: Register indices are the printed object indices
package stop_cfg_pkg;
	localparam int CLK_PERIOD_NS = 50;
	localparam int MS_NS = 1000000;
	localparam int CYCLES_PER_MS = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// Parameter object indices
	localparam logic [15:0] IDX_REGEN_PEAK_DURATION = 16'h200e;
	localparam logic [15:0] IDX_OVERLOAD_CHECK_BASE = 16'h200f;
	localparam logic [15:0] IDX_OVERLOAD_WARNING_LEVEL = 16'h2010;
	localparam logic [15:0] IDX_PWM_OFF_DELAY = 16'h2011;
	localparam logic [15:0] IDX_DYNAMIC_BRAKE_MODE = 16'h2012;
	localparam logic [15:0] IDX_EMERGENCY_STOP_METHOD = 16'h2013;
	localparam logic [15:0] IDX_WARNING_MASK = 16'h2014;
	localparam logic [15:0] IDX_U_PHASE_CURRENT_OFFSET = 16'h2015;

	// Values after reset
	localparam logic [15:0] RST_REGEN_PEAK_DURATION = 16'h1388;
	localparam logic [15:0] RST_OVERLOAD_CHECK_BASE = 16'h0064;
	localparam logic [15:0] RST_OVERLOAD_WARNING_LEVEL = 16'h0032;
	localparam logic [15:0] RST_PWM_OFF_DELAY = 16'h000a;
	localparam logic [15:0] RST_DYNAMIC_BRAKE_MODE = 16'h0000;
	localparam logic [15:0] RST_EMERGENCY_STOP_METHOD = 16'h0001;
	localparam logic [15:0] RST_WARNING_MASK = 16'h0000;
	localparam logic [15:0] RST_U_PHASE_CURRENT_OFFSET = 16'h0000;

	// Setting ranges
	localparam logic [15:0] MIN_REGEN_PEAK = 16'h0001;
	localparam logic [15:0] MAX_REGEN_PEAK = 16'hc350;
	localparam logic [15:0] MIN_CHECK_BASE = 16'h000a;
	localparam logic [15:0] MAX_CHECK_BASE = 16'h0078;
	localparam logic [15:0] MIN_WARN_LEVEL = 16'h000a;
	localparam logic [15:0] MAX_WARN_LEVEL = 16'h0064;
	localparam logic [15:0] MAX_PWM_OFF_DELAY = 16'h03e8;
	localparam logic [15:0] MAX_BRK_MODE = 16'h0003;
	localparam logic [15:0] MAX_HALT_METHOD = 16'h0001;
	localparam logic signed [15:0] MAX_CUR_OFFSET = 16'sh03e8;
	localparam logic signed [15:0] MIN_CUR_OFFSET = -16'sh03e8;

	// Warning mask bit positions
	localparam int WM_PHASE_LOSS = 0;
	localparam int WM_BATTERY_LOW = 1;
	localparam int WM_SOFT_LIMIT = 2;
	localparam int WM_OVERLOAD = 4;
	localparam int WM_MISMATCH = 5;
	localparam int WM_UNDERVOLTAGE = 6;
	localparam int WM_EMERGENCY = 7;
	localparam int WM_INDEX_OPEN = 14;
	localparam int WM_TQ_OFF_FAULT = 15;
	localparam logic [15:0] WM_USED_BITS = 16'h00f7;

	// Dynamic brake mode codes
	localparam logic [1:0] HOLD_AFTER_BRAKE = 2'h0;
	localparam logic [1:0] FREE_AFTER_BRAKE = 2'h1;
	localparam logic [1:0] FREE_AFTER_COAST = 2'h2;
	localparam logic [1:0] HOLD_AFTER_COAST = 2'h3;

	typedef enum {ST_RUN, ST_DECEL, ST_OFF_DELAY, ST_STOPPING, ST_STOPPED}
		stop_state_t;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [15:0] index;
		logic [15:0] wdata;
	} par_req_t;

	typedef struct packed {
		logic ack;
		logic err;
		logic [15:0] rdata;
	} par_rsp_t;
endpackage : stop_cfg_pkg

// *** ms_delay_timer.sv ***
// Purpose: Millisecond delay timer started by a pulse
// Assumes: cyc_per_ms is at least one
// Notes: done pulses one cycle; a new start restarts the count
`timescale 1ns/1ps
`default_nettype none
module ms_delay_timer #(
	parameter int CYC_PER_MS = 20000
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// Control
	input wire logic start,
	input wire logic [15:0] delay_ms,
	output logic done
);
	logic [31:0] cyc_r;
	logic [15:0] ms_left_r;
	logic run_r;

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			cyc_r <= 32'h0;
			ms_left_r <= 16'h0;
			run_r <= 1'b0;
			done <= 1'b0;
		end else begin
			done <= 1'b0;
			if (start) begin
				cyc_r <= 32'h0;
				ms_left_r <= delay_ms;
				run_r <= 1'b1;
			end else if (run_r) begin
				if (ms_left_r == 16'h0) begin
					run_r <= 1'b0;
					done <= 1'b1;
				end else if (cyc_r == 32'(CYC_PER_MS - 1)) begin
					cyc_r <= 32'h0;
					ms_left_r <= ms_left_r - 16'h1;
				end else begin
					cyc_r <= cyc_r + 32'h1;
				end
			end
		end
	end

	// [RULE_06] no early done
	chk_no_early_done: assert property (@(posedge clk) disable iff (!rst_b)
		start |=> !done) else $error("timer done right after start");
endmodule : ms_delay_timer
`default_nettype wire

// *** current_offset_sub.sv ***
// Purpose: Subtracts the phase current offset with saturation
// Assumes: Offset already range checked
// Notes: One cycle latency
`timescale 1ns/1ps
`default_nettype none
module current_offset_sub (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// Data
	input wire logic signed [15:0] meas,
	input wire logic signed [15:0] offset,
	output logic signed [15:0] actual
);
	logic signed [16:0] diff;

	assign diff = 17'(meas) - 17'(offset);

	// [RULE_17] subtract and saturate
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			actual <= 16'sh0000;
		end else if (diff > 17'sh07fff) begin
			actual <= 16'sh7fff;
		end else if (diff < -17'sh08000) begin
			actual <= -16'sh8000;
		end else begin
			actual <= diff[15:0];
		end
	end

	// [RULE_17] offset subtracted
	chk_offset_sub: assert property (@(posedge clk) disable iff (!rst_b)
		(offset == 16'sh0000) |=> (actual == $past(meas)))
		else $error("zero offset changed the current");
endmodule : current_offset_sub
`default_nettype wire

// *** servo_protection_stop_config.sv ***
// Purpose: Protection and stop configuration of a servo drive
// Assumes: Inputs synchronous to clk; motor_stopped from speed logic
// Notes: Parameter port answers every request one cycle later
//
// Overview of operation
// [RULE_01] Hold peak duration, default 5000 ms
// [RULE_02] Ignore peak duration with internal resistor
// [RULE_03] Accumulate overload above the check base
// [RULE_04] Lower base starts accumulation earlier
// [RULE_05] Overload warning at configured accumulated level
// [RULE_06] PWM stays on for off delay
// [RULE_07] Brake output first, PWM off later
// [RULE_08] Dynamic brake mode chooses stop behaviour
// [RULE_09] Limits or halt input cause emergency stop
// [RULE_10] Method 0 brakes, then zero torque
// [RULE_11] Method 1 decelerates with stop torque
// [RULE_12] Torque mode never uses decelerate method
// [RULE_13] Mask bit set suppresses that warning
// [RULE_14] Fixed warning bit assignment, reserved zero
// [RULE_15] Bit 14 masks encoder index alarm
// [RULE_16] Bit 15 sets fault on open torque off
// [RULE_17] Subtract U phase offset from current
// [RULE_18] Resistor select 0 internal, 1 external
// [RULE_19] Reject out of range writes
`timescale 1ns/1ps
`default_nettype none
module servo_protection_stop_config
	import stop_cfg_pkg::*;
#(
	parameter int CYC_PER_MS = stop_cfg_pkg::CYCLES_PER_MS
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// Parameter access
	input wire stop_cfg_pkg::par_req_t par_req,
	output stop_cfg_pkg::par_rsp_t par_rsp,
	// Drive state
	input wire logic servo_on_cmd,
	input wire logic torque_mode,
	input wire logic motor_stopped,
	input wire logic regen_external_sel,
	// Emergency inputs
	input wire logic positive_travel_limit_input,
	input wire logic negative_travel_limit_input,
	input wire logic emergency_halt_input,
	input wire logic safe_torque_off_input,
	// Load monitoring
	input wire logic [15:0] load_factor,
	input wire logic [15:0] overload_rate,
	input wire logic [15:0] warning_raw,
	input wire logic encoder_index_open_raw,
	// Current path
	input wire logic signed [15:0] u_current_meas,
	output logic signed [15:0] u_current_actual,
	// Power stage
	output logic pwm_enable,
	output logic brake_output,
	output logic dynamic_braking,
	output logic torque_zero,
	output logic halt_decel,
	// Status
	output logic overload_accumulate,
	output logic operation_overload_warning,
	output logic [15:0] warning_active,
	output logic encoder_index_open_alarm,
	output logic status_fault,
	output logic [15:0] regen_peak_duration_eff
);
	import stop_cfg_pkg::*;

	function automatic logic in_range(input logic [15:0] v,
		input logic [15:0] lo, input logic [15:0] hi);
		in_range = (v >= lo) && (v <= hi);
	endfunction : in_range

	function automatic logic brk_holds(input logic [1:0] m);
		brk_holds = (m == HOLD_AFTER_BRAKE) || (m == HOLD_AFTER_COAST);
	endfunction : brk_holds

	logic [15:0] regen_peak_duration_r;
	logic [15:0] overload_check_base_r;
	logic [15:0] overload_warning_level_r;
	logic [15:0] pwm_off_delay_r;
	logic [1:0] dynamic_brake_mode_r;
	logic emergency_stop_method_r;
	logic [15:0] warning_mask_r;
	logic signed [15:0] u_phase_current_offset_r;
	logic wr_ok;
	logic known_idx;
	logic [15:0] rd_val;
	stop_state_t state_r;
	stop_state_t state_nxt;
	logic halt_any;
	logic use_decel;
	logic servo_on_d_r;
	logic timer_start;
	logic timer_done;
	logic ovl_warn_raw;

	////////////////////////////////////////////////////////////////////////
	// Parameter decode

	always_comb begin
		wr_ok = 1'b0;
		known_idx = 1'b1;
		rd_val = 16'h0000;
		case (par_req.index)
		IDX_REGEN_PEAK_DURATION: begin
			wr_ok = in_range(par_req.wdata, MIN_REGEN_PEAK, MAX_REGEN_PEAK);
			rd_val = regen_peak_duration_r;
		end
		IDX_OVERLOAD_CHECK_BASE: begin
			wr_ok = in_range(par_req.wdata, MIN_CHECK_BASE, MAX_CHECK_BASE);
			rd_val = overload_check_base_r;
		end
		IDX_OVERLOAD_WARNING_LEVEL: begin
			wr_ok = in_range(par_req.wdata, MIN_WARN_LEVEL, MAX_WARN_LEVEL);
			rd_val = overload_warning_level_r;
		end
		IDX_PWM_OFF_DELAY: begin
			wr_ok = in_range(par_req.wdata, 16'h0000, MAX_PWM_OFF_DELAY);
			rd_val = pwm_off_delay_r;
		end
		IDX_DYNAMIC_BRAKE_MODE: begin
			wr_ok = in_range(par_req.wdata, 16'h0000, MAX_BRK_MODE);
			rd_val = {14'h0000, dynamic_brake_mode_r};
		end
		IDX_EMERGENCY_STOP_METHOD: begin
			wr_ok = in_range(par_req.wdata, 16'h0000, MAX_HALT_METHOD);
			rd_val = {15'h0000, emergency_stop_method_r};
		end
		IDX_WARNING_MASK: begin
			wr_ok = 1'b1;
			rd_val = warning_mask_r;
		end
		IDX_U_PHASE_CURRENT_OFFSET: begin
			wr_ok = ($signed(par_req.wdata) >= MIN_CUR_OFFSET) &&
				($signed(par_req.wdata) <= MAX_CUR_OFFSET);
			rd_val = u_phase_current_offset_r;
		end
		default: begin
			known_idx = 1'b0;
		end
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// Parameter storage

	// [RULE_19] range checked writes
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			regen_peak_duration_r <= RST_REGEN_PEAK_DURATION;
			overload_check_base_r <= RST_OVERLOAD_CHECK_BASE;
			overload_warning_level_r <= RST_OVERLOAD_WARNING_LEVEL;
			pwm_off_delay_r <= RST_PWM_OFF_DELAY;
			dynamic_brake_mode_r <= RST_DYNAMIC_BRAKE_MODE[1:0];
			emergency_stop_method_r <= RST_EMERGENCY_STOP_METHOD[0];
			warning_mask_r <= RST_WARNING_MASK;
			u_phase_current_offset_r <= RST_U_PHASE_CURRENT_OFFSET;
		end else if (par_req.wr && wr_ok) begin
			case (par_req.index)
			IDX_REGEN_PEAK_DURATION: regen_peak_duration_r <= par_req.wdata;
			IDX_OVERLOAD_CHECK_BASE: overload_check_base_r <= par_req.wdata;
			IDX_OVERLOAD_WARNING_LEVEL: begin
				overload_warning_level_r <= par_req.wdata;
			end
			IDX_PWM_OFF_DELAY: pwm_off_delay_r <= par_req.wdata;
			IDX_DYNAMIC_BRAKE_MODE: dynamic_brake_mode_r <= par_req.wdata[1:0];
			IDX_EMERGENCY_STOP_METHOD: begin
				emergency_stop_method_r <= par_req.wdata[0];
			end
			IDX_WARNING_MASK: warning_mask_r <= par_req.wdata;
			IDX_U_PHASE_CURRENT_OFFSET: begin
				u_phase_current_offset_r <= par_req.wdata;
			end
			default: begin
			end
			endcase
		end
	end

	// Write wins if both strobes are given in one cycle
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			par_rsp <= '0;
		end else begin
			par_rsp.ack <= par_req.wr || par_req.rd;
			par_rsp.err <= par_req.wr ? !wr_ok : (par_req.rd && !known_idx);
			par_rsp.rdata <= (par_req.rd && !par_req.wr) ? rd_val : 16'h0000;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Stop sequencing

	// [RULE_09] any travel limit or halt input
	assign halt_any = positive_travel_limit_input ||
		negative_travel_limit_input || emergency_halt_input;
	// [RULE_12] torque mode blocks decel
	assign use_decel = emergency_stop_method_r && !torque_mode;
	assign timer_start = (state_r != ST_OFF_DELAY) &&
		(state_nxt == ST_OFF_DELAY);

	always_comb begin
		state_nxt = state_r;
		case (state_r)
		ST_RUN: begin
			// [RULE_11] decelerate on emergency
			if (halt_any && use_decel) begin
				state_nxt = ST_DECEL;
			end else if (halt_any || !servo_on_cmd) begin
				state_nxt = ST_OFF_DELAY;
			end
		end
		ST_DECEL: begin
			if (motor_stopped) begin
				state_nxt = ST_OFF_DELAY;
			end
		end
		ST_OFF_DELAY: begin
			if (timer_done) begin
				state_nxt = ST_STOPPING;
			end
		end
		ST_STOPPING: begin
			if (motor_stopped) begin
				state_nxt = ST_STOPPED;
			end
		end
		ST_STOPPED: begin
			if (servo_on_cmd && !servo_on_d_r && !halt_any) begin
				state_nxt = ST_RUN;
			end
		end
		default: state_nxt = ST_STOPPED;
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			state_r <= ST_STOPPED;
			servo_on_d_r <= 1'b1;
		end else begin
			state_r <= state_nxt;
			servo_on_d_r <= servo_on_cmd;
		end
	end

	// [RULE_06] off delay timer
	ms_delay_timer #(
		.CYC_PER_MS(CYC_PER_MS)
	) u_off_delay (
		.clk(clk),
		.rst_b(rst_b),
		.start(timer_start),
		.delay_ms(pwm_off_delay_r),
		.done(timer_done)
	);

	// [RULE_07] brake first, PWM later
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			pwm_enable <= 1'b0;
			brake_output <= 1'b1;
			halt_decel <= 1'b0;
		end else begin
			pwm_enable <= (state_nxt == ST_RUN) || (state_nxt == ST_DECEL) ||
				(state_nxt == ST_OFF_DELAY);
			brake_output <= (state_nxt != ST_RUN) && (state_nxt != ST_DECEL);
			halt_decel <= (state_nxt == ST_DECEL);
		end
	end

	// [RULE_08] brake mode per stop phase
	// [RULE_10] zero torque in stopping and stopped states
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			dynamic_braking <= 1'b0;
			torque_zero <= 1'b1;
		end else begin
			case (state_nxt)
			ST_STOPPING: dynamic_braking <= !dynamic_brake_mode_r[1];
			ST_STOPPED: dynamic_braking <= brk_holds(dynamic_brake_mode_r);
			default: dynamic_braking <= 1'b0;
			endcase
			torque_zero <= (state_nxt == ST_STOPPING) ||
				(state_nxt == ST_STOPPED);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Overload and warnings

	// [RULE_05] warning at configured level
	assign ovl_warn_raw = overload_rate >= overload_warning_level_r;

	// [RULE_03] accumulate above base
	// [RULE_04] lower base, earlier start
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			overload_accumulate <= 1'b0;
			operation_overload_warning <= 1'b0;
		end else begin
			overload_accumulate <= load_factor > overload_check_base_r;
			operation_overload_warning <= ovl_warn_raw &&
				!warning_mask_r[WM_OVERLOAD];
		end
	end

	// [RULE_13] masked warnings suppressed
	// [RULE_14] reserved bits read zero
	// [RULE_15] index alarm mask
	// [RULE_16] fault on open torque off
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			warning_active <= 16'h0000;
			encoder_index_open_alarm <= 1'b0;
			status_fault <= 1'b0;
		end else begin
			warning_active <= ({warning_raw[15:5], ovl_warn_raw,
				warning_raw[3:0]} & ~warning_mask_r) & WM_USED_BITS;
			encoder_index_open_alarm <= encoder_index_open_raw &&
				!warning_mask_r[WM_INDEX_OPEN];
			status_fault <= !safe_torque_off_input &&
				warning_mask_r[WM_TQ_OFF_FAULT];
		end
	end

	// [RULE_01] peak duration in use
	// [RULE_02] internal resistor ignores it
	// [RULE_18] select 1 is external
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			regen_peak_duration_eff <= 16'h0000;
		end else begin
			regen_peak_duration_eff <= regen_external_sel ?
				regen_peak_duration_r : 16'h0000;
		end
	end

	// [RULE_17] current offset path
	current_offset_sub u_cur_off (
		.clk(clk),
		.rst_b(rst_b),
		.meas(u_current_meas),
		.offset(u_phase_current_offset_r),
		.actual(u_current_actual)
	);

	////////////////////////////////////////////////////////////////////////
	// Checks

	chk_bad_write_kept: assert property (@(posedge clk) disable iff (!rst_b)
		(par_req.wr && par_req.index == IDX_PWM_OFF_DELAY &&
		par_req.wdata > MAX_PWM_OFF_DELAY) |=>
		(pwm_off_delay_r == $past(pwm_off_delay_r)) && par_rsp.err)
		else $error("out of range write was stored"); // [RULE_19]

	chk_brake_before_pwm: assert property (@(posedge clk) disable iff (!rst_b)
		$fell(pwm_enable) |-> $past(brake_output))
		else $error("PWM off without brake output first"); // [RULE_07]

	chk_off_delay_holds: assert property (@(posedge clk) disable iff (!rst_b)
		(state_r == ST_RUN && !servo_on_cmd && !halt_any &&
		pwm_off_delay_r != 16'h0000) |=> pwm_enable [*3])
		else $error("PWM dropped before off delay"); // [RULE_06]

	chk_halt_leaves_run: assert property (@(posedge clk) disable iff (!rst_b)
		(state_r == ST_RUN && halt_any) |=> brake_output || halt_decel)
		else $error("emergency input not acted on"); // [RULE_09]

	chk_torque_no_decel: assert property (@(posedge clk) disable iff (!rst_b)
		torque_mode && $past(torque_mode) && state_r != ST_DECEL |=>
		!halt_decel)
		else $error("decel stop used in torque mode"); // [RULE_12]

	chk_hold_after_stop: assert property (@(posedge clk) disable iff (!rst_b)
		($past(rst_b) && state_r == ST_STOPPED &&
		$past(state_r) == ST_STOPPED) |-> (dynamic_braking ==
		brk_holds($past(dynamic_brake_mode_r))))
		else $error("wrong brake hold after stop"); // [RULE_08]

	chk_warn_masked: assert property (@(posedge clk) disable iff (!rst_b)
		warning_mask_r[WM_OVERLOAD] && $past(warning_mask_r[WM_OVERLOAD])
		|-> !operation_overload_warning)
		else $error("masked overload warning shown"); // [RULE_13]

	chk_accum_base: assert property (@(posedge clk) disable iff (!rst_b)
		##1 overload_accumulate ==
		($past(load_factor) > $past(overload_check_base_r)))
		else $error("accumulation not tied to base"); // [RULE_03]

	chk_regen_ignored: assert property (@(posedge clk) disable iff (!rst_b)
		!regen_external_sel |=> regen_peak_duration_eff == 16'h0000)
		else $error("peak duration used with internal resistor"); // [RULE_02]
endmodule : servo_protection_stop_config
`default_nettype wire

// *** motor_model.sv ***
// Purpose: Speed model of the driven motor for the stop block bench
// Assumes: Speed decays a fixed count once torque goes away
// Notes: Braked and free-run stops take equal time, a simplification
`timescale 1ns/1ps
`default_nettype none
module motor_model #(
	parameter int STOP_CYC = 10
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// Drive outputs
	input wire logic pwm_enable,
	input wire logic halt_decel,
	// Speed state
	output logic motor_stopped
);
	int spd;
	////////////////////////////////////////
	// Running while driven, decays after PWM off or during deceleration
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			spd <= 0;
		end else if (pwm_enable && !halt_decel) begin
			spd <= STOP_CYC;
		end else if (spd > 0) begin
			spd <= spd - 1;
		end
	end
	assign motor_stopped = (spd == 0);
endmodule : motor_model
`default_nettype wire

// *** tb_servo_protection_stop_config.sv ***
// Purpose: Self-checking bench for the protection and stop block
// Assumes: One millisecond shortened to four clocks
// Notes: Inputs change and outputs are sampled on the falling edge
`timescale 1ns/1ps
`default_nettype none
module tb_servo_protection_stop_config;
	import stop_cfg_pkg::*;
	localparam int CPM = 4;
	logic clk, rst_b, er, servo_on_cmd, torque_mode, motor_stopped;
	logic regen_external_sel, tq_off_in, index_raw, pwm_enable, brake_output;
	logic dynamic_braking, torque_zero, halt_decel, overload_accumulate;
	logic operation_overload_warning, encoder_index_open_alarm, status_fault;
	logic [2:0] halt;
	logic [15:0] load_factor, overload_rate, warning_raw, warning_active;
	logic [15:0] regen_eff, rd;
	logic [15:0] exp_tab [8];
	logic [15:0] bad_idx [11];
	logic [15:0] bad_val [11];
	logic [15:0] ok_idx [5];
	logic [15:0] ok_val [5];
	logic [15:0] masks [4];
	logic signed [15:0] u_meas, u_act;
	par_req_t par_req;
	par_rsp_t par_rsp;
	int err_total, checks_done;
	servo_protection_stop_config #(.CYC_PER_MS(CPM)) uut (.clk(clk),
		.rst_b(rst_b), .par_req(par_req), .par_rsp(par_rsp),
		.servo_on_cmd(servo_on_cmd), .torque_mode(torque_mode),
		.motor_stopped(motor_stopped),
		.regen_external_sel(regen_external_sel),
		.positive_travel_limit_input(halt[0]),
		.negative_travel_limit_input(halt[1]),
		.emergency_halt_input(halt[2]), .safe_torque_off_input(tq_off_in),
		.load_factor(load_factor), .overload_rate(overload_rate),
		.warning_raw(warning_raw), .encoder_index_open_raw(index_raw),
		.u_current_meas(u_meas), .u_current_actual(u_act),
		.pwm_enable(pwm_enable), .brake_output(brake_output),
		.dynamic_braking(dynamic_braking), .torque_zero(torque_zero),
		.halt_decel(halt_decel),
		.overload_accumulate(overload_accumulate),
		.operation_overload_warning(operation_overload_warning),
		.warning_active(warning_active),
		.encoder_index_open_alarm(encoder_index_open_alarm),
		.status_fault(status_fault), .regen_peak_duration_eff(regen_eff));
	motor_model #(.STOP_CYC(10)) motor (.clk(clk), .rst_b(rst_b),
		.pwm_enable(pwm_enable), .halt_decel(halt_decel),
		.motor_stopped(motor_stopped));
	////////////////////////////////////////
	task automatic finish_test();
		$display("mismatches %0d checks %0d", err_total, checks_done);
		if (err_total == 0 && checks_done > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : finish_test
	task automatic check(input logic [15:0] got, input logic [15:0] exp,
		input string what);
		checks_done++;
		if (got !== exp) begin
			err_total++;
			$display("FAIL %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : check
	task automatic settle();
		repeat (2) @(negedge clk);
	endtask : settle
	// Answer is registered, so it is seen at the falling edge after taking
	task automatic par(input logic w, input logic [15:0] idx,
		input logic [15:0] d);
		int n;
		@(negedge clk);
		par_req = '{wr: w, rd: !w, index: idx, wdata: d};
		@(negedge clk);
		par_req = '0;
		n = 0;
		while (par_rsp.ack !== 1'b1) begin
			@(negedge clk);
			n++;
			if (n > 3) begin
				err_total++;
				$display("FAIL %0t no answer", $time);
				finish_test();
			end
		end
		rd = par_rsp.rdata;
		er = par_rsp.err;
	endtask : par
	task automatic wait_lvl(ref logic s, input logic v, input int lim,
		output int n);
		n = 0;
		while (s !== v) begin
			@(negedge clk);
			n++;
			if (n > lim) begin
				err_total++;
				$display("FAIL %0t wait ran out", $time);
				finish_test();
			end
		end
	endtask : wait_lvl
	task automatic stop_case(input logic [1:0] m);
		int n;
		par(1'b1, IDX_DYNAMIC_BRAKE_MODE, {14'h0, m});
		servo_on_cmd = 1'b1;
		wait_lvl(pwm_enable, 1'b1, 20, n);
		check({15'h0, brake_output}, 16'h0, "brake while on");
		servo_on_cmd = 1'b0;
		wait_lvl(brake_output, 1'b1, 3, n);
		check({15'h0, pwm_enable}, 16'h1, "pwm after brake");
		wait_lvl(pwm_enable, 1'b0, 40, n);
		check(16'(n >= 2 * CPM - 1 && n <= 2 * CPM + 4), 16'h1,
			"off delay");
		check({15'h0, torque_zero}, 16'h1, "torque zero");
		check({15'h0, dynamic_braking}, {15'h0, m < 2'h2},
			"stop");
		wait_lvl(motor_stopped, 1'b1, 40, n);
		settle();
		check({15'h0, dynamic_braking}, {15'h0, m == 2'h0 || m == 2'h3},
			"hold");
	endtask : stop_case
	task automatic halt_case(input int k, input logic meth, input logic tq);
		int n;
		par(1'b1, IDX_EMERGENCY_STOP_METHOD, {15'h0, meth});
		torque_mode = tq;
		servo_on_cmd = 1'b1;
		wait_lvl(pwm_enable, 1'b1, 20, n);
		halt[k] = 1'b1;
		settle();
		check({15'h0, halt_decel}, {15'h0, meth && !tq},
			"decel");
		wait_lvl(pwm_enable, 1'b0, 80, n);
		check({15'h0, torque_zero}, 16'h1, "halt torque");
		if (!meth) begin
			check({15'h0, dynamic_braking}, 16'h1, "halt brake");
		end
		wait_lvl(motor_stopped, 1'b1, 40, n);
		halt[k] = 1'b0;
		servo_on_cmd = 1'b0;
		torque_mode = 1'b0;
		settle();
	endtask : halt_case
	////////////////////////////////////////
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	initial begin
		err_total = 0;
		checks_done = 0;
		rst_b = 1'b0;
		par_req = '0;
		servo_on_cmd = 1'b0;
		torque_mode = 1'b0;
		regen_external_sel = 1'b0;
		halt = 3'h0;
		tq_off_in = 1'b1;
		index_raw = 1'b0;
		load_factor = 16'h0;
		overload_rate = 16'h0;
		warning_raw = 16'h0;
		u_meas = 16'sh0;
		exp_tab = '{16'h1388, 16'h0064, 16'h0032, 16'h000a, 16'h0000,
			16'h0001, 16'h0000, 16'h0000};
		bad_idx = '{16'h200e, 16'h200e, 16'h200f, 16'h200f, 16'h2010,
			16'h2010, 16'h2011, 16'h2012, 16'h2013, 16'h2015, 16'h2015};
		bad_val = '{16'h0000, 16'hc351, 16'h0009, 16'h0079, 16'h0009,
			16'h0065, 16'h03e9, 16'h0004, 16'h0002, 16'h03e9, 16'hfc17};
		ok_idx = '{16'h200e, 16'h200f, 16'h2010, 16'h2011, 16'h2015};
		ok_val = '{16'hc350, 16'h0050, 16'h000a, 16'h0002, 16'h0064};
		masks = '{16'h0000, 16'h00a5, 16'hc000, 16'hffff};
		repeat (3) @(negedge clk);
		rst_b = 1'b1;
		for (int i = 0; i < 8; i++) begin
			par(1'b0, 16'h200e + 16'(i), 16'h0);
			check(rd, exp_tab[i], "default");
		end
		par(1'b0, 16'h2016, 16'h0);
		check({15'h0, er}, 16'h1, "unknown index");
		for (int i = 0; i < 11; i++) begin
			par(1'b1, bad_idx[i], bad_val[i]);
			check({15'h0, er}, 16'h1, "range refused");
			par(1'b0, bad_idx[i], 16'h0);
			check(rd, exp_tab[bad_idx[i] - 16'h200e], "kept");
		end
		for (int i = 0; i < 5; i++) begin
			par(1'b1, ok_idx[i], ok_val[i]);
			check({15'h0, er}, 16'h0, "edge accepted");
			par(1'b0, ok_idx[i], 16'h0);
			check(rd, ok_val[i], "readback");
		end
		settle();
		check(regen_eff, 16'h0, "internal");
		regen_external_sel = 1'b1;
		settle();
		check(regen_eff, 16'hc350, "external");
		load_factor = 16'd80;
		settle();
		check({15'h0, overload_accumulate}, 16'h0, "at base");
		load_factor = 16'd81;
		settle();
		check({15'h0, overload_accumulate}, 16'h1, "over base");
		overload_rate = 16'd9;
		settle();
		check({15'h0, operation_overload_warning}, 16'h0, "low");
		overload_rate = 16'd10;
		settle();
		check({15'h0, operation_overload_warning}, 16'h1,
			"level");
		par(1'b1, IDX_WARNING_MASK, 16'h0010);
		settle();
		check({15'h0, operation_overload_warning}, 16'h0,
			"mask4");
		overload_rate = 16'h0;
		warning_raw = 16'hffff;
		index_raw = 1'b1;
		tq_off_in = 1'b0;
		for (int i = 0; i < 4; i++) begin
			par(1'b1, IDX_WARNING_MASK, masks[i]);
			settle();
			check(warning_active, 16'h00e7 & ~masks[i], "warn");
			check({15'h0, encoder_index_open_alarm}, {15'h0, !masks[i][14]},
				"index alarm");
			check({15'h0, status_fault}, {15'h0, masks[i][15]},
				"open input fault");
		end
		tq_off_in = 1'b1;
		settle();
		check({15'h0, status_fault}, 16'h0, "input present");
		u_meas = 16'sd500;
		settle();
		check(u_act, 16'h0190, "offset");
		par(1'b1, IDX_U_PHASE_CURRENT_OFFSET, 16'hfc18);
		u_meas = 16'sh7fff;
		settle();
		check(u_act, 16'h7fff, "saturate");
		for (int m = 0; m < 4; m++) begin
			stop_case(2'(m));
		end
		par(1'b1, IDX_DYNAMIC_BRAKE_MODE, 16'h0);
		for (int k = 0; k < 3; k++) begin
			halt_case(k, 1'b1, 1'b0);
		end
		halt_case(0, 1'b1, 1'b1);
		halt_case(2, 1'b0, 1'b0);
		finish_test();
	end
endmodule : tb_servo_protection_stop_config
`default_nettype wire
